// ---- core/mfsc_map.svh ----
// Register map, field positions and match thresholds of the modem config
`ifndef MFSC_MAP_SVH
`define MFSC_MAP_SVH

`define CFG_ADDR 6'h12
`define CFG_RESET 8'h02
`define CFG_DCBYP_BIT 7
`define CFG_MOD_HI 6
`define CFG_MOD_LO 4
`define CFG_MANCH_BIT 3
`define CFG_SYNC_HI 2
`define CFG_SYNC_LO 0
`define CFG_SYNC_CS_BIT 2
`define SPI_HDR_BITS 5'd8
`define SPI_FRAME_BITS 5'd16
`define SPI_RW_POS 6
`define MATCH_16_LOOSE 6'd15
`define MATCH_16_FULL 6'd16
`define MATCH_32_LOOSE 6'd30

`endif

// ---- core/mfsc_pkg.sv ----
// Types and shared decode for the modem format and sync configuration
`include "mfsc_map.svh"
package mfsc_pkg;

  typedef enum logic [2:0] {
    MOD_2FSK = 3'h0,
    MOD_GFSK = 3'h1,
    MOD_OOK = 3'h3,
    MOD_4FSK = 3'h4
  } mod_t;

  typedef logic [2:0] sync_mode_t;

  // Least number of matching sync bits for a qualifier code
  function automatic logic [5:0] min_match(input sync_mode_t mode);
    unique case (mode[1:0])
      2'h1: min_match = `MATCH_16_LOOSE;
      2'h2: min_match = `MATCH_16_FULL;
      2'h3: min_match = `MATCH_32_LOOSE;
      default: min_match = 6'h00;
    endcase
  endfunction : min_match

endpackage : mfsc_pkg

// ---- core/modem_format_sync_config.sv ----
// Modem format and sync qualifier register with its serial port access
`timescale 1ns/10ps
`include "mfsc_map.svh"
module modem_format_sync_config (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Serial configuration port
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic mosi,
  output logic miso,
  output logic miso_oe_n,
  // Receive path
  input wire logic rx_start,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic carrier_sense,
  input wire logic [31:0] sync_word,
  // Settings in force for the current reception
  output logic dc_block_bypass,
  output logic [2:0] modulation_select,
  output logic mod_reserved,
  output logic manchester_en,
  output logic sync_search_en,
  output logic sync_len32,
  output logic cs_required,
  // Qualifier results
  output logic sync_found,
  output logic cs_qualified
);

  // Serial port state
  logic prev_sclk;
  logic [4:0] bit_cnt;
  logic [7:0] in_shift;
  logic [7:0] out_shift;
  logic hdr_read;
  logic hdr_hit;
  logic [7:0] cfg;
  logic next_prev_sclk;
  logic [4:0] next_bit_cnt;
  logic [7:0] next_in_shift;
  logic [7:0] next_out_shift;
  logic next_hdr_read;
  logic next_hdr_hit;
  logic [7:0] next_cfg;
  logic rise;
  logic fall;
  logic write_commit;

  assign rise = !cs_n && sclk && !prev_sclk;
  assign fall = !cs_n && !sclk && prev_sclk;
  assign miso = out_shift[7];
  assign miso_oe_n = cs_n;

  always_comb begin
    next_prev_sclk = sclk;
    next_bit_cnt = bit_cnt;
    next_in_shift = in_shift;
    next_out_shift = out_shift;
    next_hdr_read = hdr_read;
    next_hdr_hit = hdr_hit;
    next_cfg = cfg;
    write_commit = 1'b0;
    if (cs_n) begin
      next_bit_cnt = 5'h00;
      next_out_shift = 8'h00;
    end else begin
      if (rise) begin
        next_in_shift = {in_shift[6:0], mosi};
        // Extra bytes of a burst are ignored: no neighbour lives here
        if (bit_cnt != `SPI_FRAME_BITS) begin
          next_bit_cnt = 5'(bit_cnt + 5'h01);
        end
        if (bit_cnt == `SPI_HDR_BITS - 5'h01) begin
          next_hdr_read = in_shift[`SPI_RW_POS];
          next_hdr_hit = {in_shift[4:0], mosi} == `CFG_ADDR;
          // Read data is loaded early so bit 7 is ready before the next rise
          next_out_shift = (in_shift[`SPI_RW_POS] &&
                            {in_shift[4:0], mosi} == `CFG_ADDR) ? cfg : 8'h00;
        end
        if (bit_cnt == `SPI_FRAME_BITS - 5'h01 && !hdr_read && hdr_hit) begin
          next_cfg = {in_shift[6:0], mosi};
          write_commit = 1'b1;
        end
      end
      if (fall && bit_cnt > `SPI_HDR_BITS) begin
        next_out_shift = {out_shift[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prev_sclk <= 1'b0;
      bit_cnt <= 5'h00;
      in_shift <= 8'h00;
      out_shift <= 8'h00;
      hdr_read <= 1'b0;
      hdr_hit <= 1'b0;
      cfg <= `CFG_RESET;
    end else begin
      prev_sclk <= next_prev_sclk;
      bit_cnt <= next_bit_cnt;
      in_shift <= next_in_shift;
      out_shift <= next_out_shift;
      hdr_read <= next_hdr_read;
      hdr_hit <= next_hdr_hit;
      cfg <= next_cfg;
    end
  end

  // Settings in force: taken from the register only at a reception start,
  // so a write mid-packet cannot disturb the packet already running
  mfsc_pkg::sync_mode_t mode;
  logic [5:0] min_bits;
  logic next_dc_block_bypass;
  logic [2:0] next_modulation_select;
  logic next_mod_reserved;
  logic next_manchester_en;
  logic next_sync_search_en;
  logic next_sync_len32;
  logic next_cs_required;
  mfsc_pkg::sync_mode_t next_mode;
  logic [5:0] next_min_bits;

  always_comb begin
    logic [2:0] m;
    logic [2:0] s;
    m = cfg[`CFG_MOD_HI:`CFG_MOD_LO];
    s = cfg[`CFG_SYNC_HI:`CFG_SYNC_LO];
    next_dc_block_bypass = dc_block_bypass;
    next_modulation_select = modulation_select;
    next_mod_reserved = mod_reserved;
    next_manchester_en = manchester_en;
    next_sync_search_en = sync_search_en;
    next_sync_len32 = sync_len32;
    next_cs_required = cs_required;
    next_mode = mode;
    next_min_bits = min_bits;
    if (rx_start) begin
      next_dc_block_bypass = cfg[`CFG_DCBYP_BIT];
      next_modulation_select = m;
      next_mod_reserved = !(m == mfsc_pkg::MOD_2FSK ||
                            m == mfsc_pkg::MOD_GFSK ||
                            m == mfsc_pkg::MOD_OOK ||
                            m == mfsc_pkg::MOD_4FSK);
      next_manchester_en = cfg[`CFG_MANCH_BIT];
      next_sync_search_en = s[1:0] != 2'h0;
      next_sync_len32 = s[1:0] == 2'h3;
      next_cs_required = s[`CFG_SYNC_CS_BIT];
      next_mode = s;
      next_min_bits = mfsc_pkg::min_match(s);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dc_block_bypass <= 1'b0;
      modulation_select <= mfsc_pkg::MOD_2FSK;
      mod_reserved <= 1'b0;
      manchester_en <= 1'b0;
      sync_search_en <= 1'b1;
      sync_len32 <= 1'b0;
      cs_required <= 1'b0;
      mode <= 3'(`CFG_RESET);
      min_bits <= `MATCH_16_FULL;
    end else begin
      dc_block_bypass <= next_dc_block_bypass;
      modulation_select <= next_modulation_select;
      mod_reserved <= next_mod_reserved;
      manchester_en <= next_manchester_en;
      sync_search_en <= next_sync_search_en;
      sync_len32 <= next_sync_len32;
      cs_required <= next_cs_required;
      mode <= next_mode;
      min_bits <= next_min_bits;
    end
  end

  // Sync search
  logic [5:0] match_count;
  logic count_valid;
  logic next_sync_found;
  logic next_cs_qualified;

  sync_matcher matcher (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .clear(rx_start),
    .bit_in(rx_bit),
    .bit_valid(rx_bit_valid),
    .pattern(sync_word),
    .len32(sync_len32),
    .match_count(match_count),
    .count_valid(count_valid)
  );

  always_comb begin
    next_sync_found = count_valid && sync_search_en &&
                      match_count >= min_bits &&
                      (!cs_required || carrier_sense);
    // Code 4 qualifies on carrier alone, with no word search
    next_cs_qualified = !sync_search_en && cs_required && carrier_sense;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      sync_found <= 1'b0;
      cs_qualified <= 1'b0;
    end else begin
      sync_found <= next_sync_found;
      cs_qualified <= next_cs_qualified;
    end
  end

  // Checks
  sequence commit_s;
    rise && bit_cnt == `SPI_FRAME_BITS - 5'h01 && !hdr_read && hdr_hit;
  endsequence

  sequence apply_s;
    ##[1:8] rx_start ##1 1'b1;
  endsequence

  reset_value_a: assert property (@(posedge ref_clk)
    sys_rst |=> cfg == `CFG_RESET && !manchester_en)
    else $error("register reset value wrong");

  write_store_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    commit_s |=> cfg == {$past(in_shift[6:0]), $past(mosi)})
    else $error("write not stored");

  write_apply_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    commit_s ##1 (!write_commit) [*1] ##0 apply_s |->
      manchester_en == cfg[`CFG_MANCH_BIT] || write_commit)
    else $error("written setting not applied");

  bypass_load_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rx_start |=> dc_block_bypass == $past(cfg[`CFG_DCBYP_BIT]))
    else $error("bypass bit not taken");

  mod_decode_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rx_start |=> mod_reserved ==
      ($past(cfg[`CFG_MOD_HI:`CFG_MOD_LO]) inside {3'h2, 3'h5, 3'h6, 3'h7}))
    else $error("modulation reserved flag wrong");

  no_sync_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode[1:0] == 2'h0 |=> !sync_found)
    else $error("sync found with detection off");

  len16_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    mode[1:0] inside {2'h1, 2'h2} |-> !sync_len32)
    else $error("wrong sync length");

  thresh16_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sync_found && !sync_len32 |->
      $past(match_count) >=
        (mode[1:0] == 2'h1 ? `MATCH_16_LOOSE : `MATCH_16_FULL))
    else $error("16-bit threshold broken");

  thresh32_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    sync_found && sync_len32 |-> $past(match_count) >= `MATCH_32_LOOSE)
    else $error("32-bit threshold broken");

  carrier_need_a: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (sync_found || cs_qualified) && mode[2] |-> $past(carrier_sense))
    else $error("carrier sense not required");

endmodule : modem_format_sync_config

// ---- core/sync_matcher.sv ----
// Sync word shift register and bit match counter
`timescale 1ns/10ps
module sync_matcher (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Received bit stream
  input wire logic clear,
  input wire logic bit_in,
  input wire logic bit_valid,
  // Expected word and length
  input wire logic [31:0] pattern,
  input wire logic len32,
  // Match result
  output logic [5:0] match_count,
  output logic count_valid
);

  logic [31:0] shift;
  logic [31:0] next_shift;
  logic [5:0] next_match_count;
  logic next_count_valid;

  function automatic logic [5:0] ones(input logic [31:0] v);
    logic [5:0] n;
    n = 6'h00;
    for (int i = 0; i < 32; i++) begin
      n = n + {5'h00, v[i]};
    end
    ones = n;
  endfunction : ones

  always_comb begin
    logic [31:0] same;
    same = 32'h0;
    next_shift = shift;
    next_match_count = match_count;
    next_count_valid = 1'b0;
    if (clear) begin
      next_shift = 32'h0;
    end else if (bit_valid) begin
      next_shift = {shift[30:0], bit_in};
      same = ~(next_shift ^ pattern);
      // The 16-bit word sits in the low half of the pattern
      if (!len32) begin
        same[31:16] = 16'h0;
      end
      next_match_count = ones(same);
      next_count_valid = 1'b1;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      shift <= 32'h0;
      match_count <= 6'h00;
      count_valid <= 1'b0;
    end else begin
      shift <= next_shift;
      match_count <= next_match_count;
      count_valid <= next_count_valid;
    end
  end

endmodule : sync_matcher

// ---- test/testbench.sv ----
// Self-checking bench for the modem format and sync qualifier register
`timescale 1ns/10ps
module testbench;
  // Clock and reset
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  // Serial configuration port
  logic cs_n = 1'b1;
  logic sclk = 1'b0;
  logic mosi = 1'b0;
  logic miso;
  logic miso_oe_n;
  // Receive path
  logic rx_start = 1'b0;
  logic rx_bit = 1'b0;
  logic rx_bit_valid = 1'b0;
  logic carrier_sense = 1'b0;
  logic [31:0] sync_word = 32'h0000_0000;
  // Observed settings and results
  logic dc_block_bypass;
  logic [2:0] modulation_select;
  logic mod_reserved;
  logic manchester_en;
  logic sync_search_en;
  logic sync_len32;
  logic cs_required;
  logic sync_found;
  logic cs_qualified;
  logic [15:0] settings_seen;
  // Bench bookkeeping
  int error_cnt = 0;
  int comparisons = 0;
  logic [17:0] notes[$];
  logic look = 1'b0;
  logic [7:0] rd_byte = 8'h00;
  logic hit = 1'b0;
  logic oe_seen = 1'b1;
  logic [7:0] v;

  always #5 ref_clk = ~ref_clk;

  assign settings_seen = {7'h00, dc_block_bypass, modulation_select,
                          mod_reserved, manchester_en, sync_search_en,
                          sync_len32, cs_required};

  modem_format_sync_config DUT (
    .ref_clk(ref_clk), .sys_rst(sys_rst),
    .cs_n(cs_n), .sclk(sclk), .mosi(mosi), .miso(miso),
    .miso_oe_n(miso_oe_n),
    .rx_start(rx_start), .rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid),
    .carrier_sense(carrier_sense), .sync_word(sync_word),
    .dc_block_bypass(dc_block_bypass),
    .modulation_select(modulation_select), .mod_reserved(mod_reserved),
    .manchester_en(manchester_en), .sync_search_en(sync_search_en),
    .sync_len32(sync_len32), .cs_required(cs_required),
    .sync_found(sync_found), .cs_qualified(cs_qualified)
  );

  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic report_and_stop();
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  // The watcher only samples on the edge where a note is pending
  task automatic note(input logic [1:0] kind, input logic [15:0] exp);
    notes.push_back({kind, exp});
    look = 1'b1;
    step(1);
    look = 1'b0;
  endtask : note

  always @(posedge ref_clk) begin : watcher
    logic [17:0] n;
    if (look) begin
      n = notes.pop_front();
      case (n[17:16])
        2'h0: check({6'h00, miso_oe_n, oe_seen, rd_byte}, n[15:0]);
        2'h1: check(settings_seen, n[15:0]);
        default: check({14'h0, cs_qualified, hit}, n[15:0]);
      endcase
    end
  end

  // Each sclk level lasts two cycles; miso is sampled mid high phase
  task automatic spi_xfer(input logic [7:0] hdr, input logic [7:0] dat);
    logic [15:0] frame;
    frame = {hdr, dat};
    cs_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      mosi = frame[i];
      step(2);
      sclk = 1'b1;
      step(1);
      if (i < 8) rd_byte[i] = miso;
      // Output enable must be low while the port is selected
      if (i == 0) oe_seen = miso_oe_n;
      step(1);
      sclk = 1'b0;
    end
    step(2);
    cs_n = 1'b1;
    mosi = ~mosi;
    step(1);
  endtask : spi_xfer

  task automatic cfg_read(input logic [5:0] addr, input logic [7:0] exp);
    spi_xfer({2'b10, addr}, 8'h00);
    note(2'h0, {6'h00, 1'b1, 1'b0, exp});
  endtask : cfg_read

  task automatic rx_pulse();
    rx_start = 1'b1;
    step(1);
    rx_start = 1'b0;
    step(1);
  endtask : rx_pulse

  function automatic logic [15:0] exp_set(input logic [7:0] c);
    logic resv;
    resv = c[6:4] inside {3'h2, 3'h5, 3'h6, 3'h7};
    exp_set = {7'h00, c[7], c[6:4], resv, c[3], c[1:0] != 2'h0,
               c[1:0] == 2'h3, c[2]};
  endfunction : exp_set

  // Sends the word with lim+extra flipped bits, lim being the tolerance
  task automatic sync_trial(input logic [2:0] code, input int extra,
                            input logic cs);
    logic [31:0] word;
    int len;
    int lim;
    logic found;
    len = (code[1:0] == 2'h3) ? 32 : 16;
    lim = (code[1:0] == 2'h1) ? 1 : (code[1:0] == 2'h3) ? 2 : 0;
    word = sync_word;
    for (int k = 0; k < lim + extra; k++) word[k] = ~word[k];
    found = code[1:0] != 2'h0 && extra == 0 && (!code[2] || cs);
    carrier_sense = cs;
    spi_xfer(8'h12, {4'h1, 1'b0, code});
    rx_pulse();
    hit = 1'b0;
    for (int i = len - 1; i >= 0; i--) begin
      rx_bit = word[i];
      rx_bit_valid = 1'b1;
      step(1);
      rx_bit_valid = 1'b0;
      rx_bit = ~rx_bit;
      repeat (2) begin
        step(1);
        hit = hit | sync_found;
      end
    end
    note(2'h2, {14'h0, code == 3'h4 && cs, found});
  endtask : sync_trial

  initial begin : watchdog
    #200us;
    error_cnt++;
    report_and_stop();
  end

  initial begin
    void'($urandom(56777));
    sync_word = $urandom;
    step(3);
    sys_rst = 1'b0;
    cfg_read(6'h12, 8'h02);
    rx_pulse();
    note(2'h1, exp_set(8'h02));
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      v[6:4] = 3'(i);
      v[2:0] = 3'(7 - i);
      // Symbol rate is never raised here, so bypass may be set freely
      v[7] = v[7];
      if (i == 4) v[3] = 1'b0;
      spi_xfer(8'h12, v);
      cfg_read(6'h12, v);
      rx_pulse();
      note(2'h1, exp_set(v));
    end
    // Unmapped address: write dropped, read returns zero
    spi_xfer(8'h13, 8'hff);
    cfg_read(6'h13, 8'h00);
    cfg_read(6'h12, v);
    for (int c = 0; c < 8; c++) begin
      for (int e = 0; e < 2; e++) begin
        sync_trial(3'(c), e, 1'($urandom));
      end
    end
    sync_trial(3'h6, 0, 1'b0);
    sys_rst = 1'b1;
    step(3);
    sys_rst = 1'b0;
    cfg_read(6'h12, 8'h02);
    report_and_stop();
  end
endmodule : testbench
